// >>> wrw_defines.vh
// constants for the windowed reset watchdog
`ifndef WRW_DEFINES_VH
`define WRW_DEFINES_VH
`define WRW_PRESCALE_CYCLES 16384
`define WRW_PRE_W 14
`define WRW_PRE_MAX 14'h3FFF
`define WRW_PRE_ONE 14'h0001
`define WRW_PRE_ZERO 14'h0000
`define WRW_CTRL_RESET 8'h7F
`define WRW_CNT_RESET 7'h7F
`define WRW_CNT_ONE 7'h01
`define WRW_TOP_BIT 6
`define WRW_ACT_BIT 7
`define WRW_RST_PULSE_NS 500
`define WRW_CLK_PERIOD_NS 100
`define WRW_RST_CYCLES ((`WRW_RST_PULSE_NS + `WRW_CLK_PERIOD_NS - 1) / `WRW_CLK_PERIOD_NS)
`define WRW_RST_CNT_W 3
`define WRW_RST_LOAD 3'h5
`define WRW_RST_CNT_ZERO 3'h0
`define WRW_RST_CNT_ONE 3'h1
`define WRW_WAKE_SHORT 256
`define WRW_WAKE_LONG 4096
`define WRW_WAKE_W 13
`define WRW_WAKE_ZERO 13'h0000
`define WRW_WAKE_ONE 13'h0001
`define WRW_WAKE_SHORT_LD 13'h0100
`define WRW_WAKE_LONG_LD 13'h1000
`define WRW_TB_W 2
`define WRW_TB_RESET 2'h0
`define WRW_LSB_TB0 8'h3B
`define WRW_LSB_TB1 8'h35
`define WRW_LSB_TB2 8'h23
`define WRW_LSB_TB3 8'h36
`define WRW_MSB_TB0 8'h04
`define WRW_MSB_TB1 8'h08
`define WRW_MSB_TB2 8'h14
`define WRW_MSB_TB3 8'h31
`endif

// >>> wrw_watchdog.v
// windowed reset watchdog: 7-bit down-counter with prescaler and reset pulse
// Overview of operation
// [RULE_01] count decrements once every 16384 oscillator clock cycles via a prescaler
// [RULE_02] lower six count bits give the prescaler periods left, 64 steps
// [RULE_03] active and count steps 40h to 3Fh: reset pin low for about 500ns
// [RULE_04] count decrements always; only reset generation depends on activation; code freezes the count while halted and during the wake delay
// [RULE_05] software rewrites control with values C0h to FFh regularly
// [RULE_06] inactive after reset; once active, only a reset deactivates it
// [RULE_07] write with activation set and top bit clear resets immediately
// [RULE_08] halt instruction while active resets, if the halt-reset option allows
// [RULE_09] hardware-watchdog option makes the watchdog active without software
// [RULE_10] control writes leave the prescaler running, so first step may be early
// [RULE_11] prescaler phase follows timebase select; bound constants kept per code
// [RULE_12] control register resets to 7Fh: inactive, all count bits set
// [RULE_13] hardware-watchdog option ignores the activation bit, always active
// [RULE_14] after halt ends by external interrupt, resume after 256 or 4096 clocks
// [RULE_15] control write loads all seven count bits, sets activation if written one
`timescale 1ns/10ps
`default_nettype none
`include "wrw_defines.vh"
module wrw_watchdog (
    // clock and reset
    input wire clk,
    input wire rst,
    // control register write port
    input wire ctrl_wr,
    input wire [7:0] ctrl_wdata,
    // option byte and clock controller
    input wire hw_watchdog_opt,
    input wire halt_reset_option,
    input wire [1:0] timebase_select,
    input wire long_wake_delay,
    // cpu events
    input wire halt_exec,
    input wire ext_wake,
    // status and reset
    output reg [7:0] watchdog_control_reg,
    output reg reset_n_q,
    output reg [7:0] bound_msb_q,
    output reg [7:0] bound_lsb_q
);
    // state registers
    reg [`WRW_PRE_W-1:0] pre_q;
    reg [6:0] cnt_q;
    reg act_q;
    reg halted_q;
    reg [`WRW_WAKE_W-1:0] wake_q;
    reg [`WRW_RST_CNT_W-1:0] rcnt_q;
    reg [1:0] tb_q;
    wire eff_act;
    wire tick;
    wire counting;
    wire [6:0] cnt_dec;
    wire expire;
    wire sw_reset;
    wire halt_reset;
    wire fire;
    // next values of the state registers
    reg [`WRW_PRE_W-1:0] pre_d;
    reg [1:0] tb_d;
    reg [6:0] cnt_d;
    reg act_d;
    reg halted_d;
    reg [`WRW_WAKE_W-1:0] wake_d;
    reg [`WRW_RST_CNT_W-1:0] rcnt_d;
    reg reset_n_d;
    reg [7:0] bound_msb_d;
    reg [7:0] bound_lsb_d;

    // effective activation and prescaler tick
    assign eff_act = act_q | hw_watchdog_opt; // RULE_09 RULE_13
    assign counting = ~halted_q && (wake_q == `WRW_WAKE_ZERO);
    assign tick = counting && (pre_q == `WRW_PRE_MAX); // RULE_01 RULE_10
    assign cnt_dec = cnt_q - `WRW_CNT_ONE;
    // top bit falls on a step from 40h to 3Fh
    assign expire = tick && cnt_q[`WRW_TOP_BIT] && ~cnt_dec[`WRW_TOP_BIT] && eff_act; // RULE_03
    // reset sources; a top-bit-clear write while active is a software reset
    assign sw_reset = ctrl_wr && (ctrl_wdata[`WRW_ACT_BIT] | eff_act)
        && ~ctrl_wdata[`WRW_TOP_BIT]; // RULE_07 RULE_13
    assign halt_reset = halt_exec && eff_act && halt_reset_option; // RULE_08
    assign fire = expire | sw_reset | halt_reset;

    // prescaler next value: restart on a timebase change, never on writes
    always @* begin
        tb_d = timebase_select;
        pre_d = pre_q;
        if (tb_q != timebase_select) begin
            pre_d = `WRW_PRE_ZERO; // RULE_11
        end else if (counting) begin
            pre_d = pre_q + `WRW_PRE_ONE; // RULE_01 RULE_10
        end
    end

    // prescaler and timebase registers
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_q <= `WRW_PRE_ZERO;
            tb_q <= `WRW_TB_RESET;
        end else begin
            pre_q <= pre_d;
            tb_q <= tb_d;
        end
    end

    // count next value: a write wins over a same-cycle tick
    always @* begin
        cnt_d = cnt_q;
        act_d = act_q;
        if (ctrl_wr) begin
            cnt_d = ctrl_wdata[`WRW_TOP_BIT:0]; // RULE_15 RULE_02
            if (ctrl_wdata[`WRW_ACT_BIT]) begin
                act_d = 1'b1; // RULE_15 RULE_06
            end
        end else if (tick) begin
            cnt_d = cnt_dec; // RULE_04
        end
    end

    // count and activation flag, activation only cleared by reset
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= `WRW_CNT_RESET; // RULE_12
            act_q <= 1'b0; // RULE_06
        end else begin
            cnt_q <= cnt_d;
            act_q <= act_d;
        end
    end

    // halt tracking and wake delay next values
    always @* begin
        halted_d = halted_q;
        wake_d = wake_q;
        if (halt_exec && ~halt_reset) begin
            halted_d = 1'b1;
        end else if (halted_q && ext_wake) begin
            halted_d = 1'b0;
            wake_d = long_wake_delay ? `WRW_WAKE_LONG_LD : `WRW_WAKE_SHORT_LD; // RULE_14
        end else if (wake_q != `WRW_WAKE_ZERO) begin
            wake_d = wake_q - `WRW_WAKE_ONE; // RULE_14
        end
    end

    // halt and wake registers; counting stays frozen until the delay ends
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            halted_q <= 1'b0;
            wake_q <= `WRW_WAKE_ZERO;
        end else begin
            halted_q <= halted_d;
            wake_q <= wake_d;
        end
    end

    // reset pulse next values; a new event restarts the pulse
    always @* begin
        rcnt_d = rcnt_q;
        reset_n_d = reset_n_q;
        if (fire) begin
            rcnt_d = `WRW_RST_LOAD; // RULE_03
            reset_n_d = 1'b0;
        end else if (rcnt_q != `WRW_RST_CNT_ZERO) begin
            rcnt_d = rcnt_q - `WRW_RST_CNT_ONE;
            reset_n_d = (rcnt_q == `WRW_RST_CNT_ONE);
        end
    end

    // reset pulse registers, pin released high
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rcnt_q <= `WRW_RST_CNT_ZERO;
            reset_n_q <= 1'b1;
        end else begin
            rcnt_q <= rcnt_d;
            reset_n_q <= reset_n_d;
        end
    end

    // status view, one cycle behind the state
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            watchdog_control_reg <= `WRW_CTRL_RESET; // RULE_12
        end else begin
            watchdog_control_reg <= {act_q, cnt_q};
        end
    end

    // timeout bound constants for the selected timebase
    always @* begin
        case (timebase_select) // RULE_11
            2'h0: begin
                bound_msb_d = `WRW_MSB_TB0;
                bound_lsb_d = `WRW_LSB_TB0;
            end
            2'h1: begin
                bound_msb_d = `WRW_MSB_TB1;
                bound_lsb_d = `WRW_LSB_TB1;
            end
            2'h2: begin
                bound_msb_d = `WRW_MSB_TB2;
                bound_lsb_d = `WRW_LSB_TB2;
            end
            default: begin
                bound_msb_d = `WRW_MSB_TB3;
                bound_lsb_d = `WRW_LSB_TB3;
            end
        endcase
    end

    // bound constant registers
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            bound_msb_q <= `WRW_MSB_TB0;
            bound_lsb_q <= `WRW_LSB_TB0;
        end else begin
            bound_msb_q <= bound_msb_d;
            bound_lsb_q <= bound_lsb_d;
        end
    end
endmodule
`default_nettype wire

// >>> wrw_watchdog_properties.sv
// assertions for the windowed reset watchdog
`timescale 1ns/10ps
`default_nettype none
module wrw_props (
    // clock and inputs
    input wire logic clk,
    input wire logic rst,
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    input wire logic hw_watchdog_opt,
    input wire logic halt_reset_option,
    input wire logic halt_exec,
    // outputs
    input wire logic [7:0] watchdog_control_reg,
    input wire logic reset_n_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // short alias of the control view
    wire [7:0] wcr = watchdog_control_reg;
    rst_val_a: assert property ($fell(rst) |-> wcr == 8'h7F && reset_n_q)
        else $error("bad state after reset");
    pulse_len_a: assert property ($fell(reset_n_q) |-> !reset_n_q [*5] ##1 reset_n_q)
        else $error("reset pulse length wrong");
    sw_reset_a: assert property (ctrl_wr && ctrl_wdata[7:6] == 2'h2 |=> !reset_n_q)
        else $error("no software reset");
    load_cnt_a: assert property (ctrl_wr |=> ##1 wcr[6:0] == $past(ctrl_wdata[6:0], 2))
        else $error("count not loaded");
    act_set_a: assert property (ctrl_wr && ctrl_wdata[7] |=> ##1 wcr[7])
        else $error("activation not set");
    act_stick_a: assert property (wcr[7] |=> wcr[7])
        else $error("activation cleared");
    halt_rst_a: assert property (halt_exec && halt_reset_option && wcr[7] |=> !reset_n_q)
        else $error("no halt reset");
    quiet_off_a: assert property (!wcr[7] && !hw_watchdog_opt && !ctrl_wr
        && !$past(ctrl_wr) && reset_n_q |=> reset_n_q) else $error("reset while inactive");
    cover property ($fell(reset_n_q));
    cover property (halt_exec && wcr[7]);
    cover property (ctrl_wr && ctrl_wdata[7]);
    cover property (halt_exec && !halt_reset_option);
endmodule
bind wrw_watchdog wrw_props u_props (.clk(clk), .rst(rst), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .hw_watchdog_opt(hw_watchdog_opt), .halt_exec(halt_exec),
    .halt_reset_option(halt_reset_option), .watchdog_control_reg(watchdog_control_reg),
    .reset_n_q(reset_n_q));
`default_nettype wire

// >>> wrw_watchdog_tb.sv
// self-checking bench for the windowed reset watchdog
`timescale 1ns/10ps
`default_nettype none
module wrw_watchdog_tb;
    logic clk = 0, rst = 1, wr = 0, hw = 0, halt = 0, opt = 1, ew = 0, lw = 0;
    logic [7:0] wd = 8'h00;
    logic [1:0] tsel = 2'h0;
    wire [7:0] wcr, msb, lsb;
    wire rn;
    int fail_count = 0, num_checks = 0, n;
    wrw_watchdog DUT (.clk(clk), .rst(rst), .ctrl_wr(wr), .ctrl_wdata(wd),
        .hw_watchdog_opt(hw), .halt_reset_option(opt), .timebase_select(tsel),
        .long_wake_delay(lw), .halt_exec(halt), .ext_wake(ew), .watchdog_control_reg(wcr),
        .reset_n_q(rn), .bound_msb_q(msb), .bound_lsb_q(lsb));
    // clock
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [7:0] d);
        wd = d;
        wr = 1;
        @(negedge clk);
        wr = 0;
    endtask
    task automatic pulse;
        n = 0;
        while (rn !== 1'b1 && n < 20) begin
            n++;
            @(negedge clk);
        end
        chk(n[7:0], 8'h05);
    endtask
    task automatic wait_cnt(input logic [6:0] v);
        n = 0;
        while (wcr[6:0] !== v && n < 17000) begin
            n++;
            @(negedge clk);
        end
        chk({7'h00, n < 17000}, 8'h01);
    endtask
    task automatic t_bounds;
        logic [7:0] em[4] = '{8'h04, 8'h08, 8'h14, 8'h31};
        logic [7:0] el[4] = '{8'h3B, 8'h35, 8'h23, 8'h36};
        chk(wcr, 8'h7F);
        for (int i = 0; i < 4; i++) begin
            tsel = i[1:0];
            repeat (3) @(negedge clk);
            chk(msb, em[i]);
            chk(lsb, el[i]);
        end
        tsel = 2'h0;
        $display("done bounds");
    endtask
    task automatic t_count;
        wr_reg(8'h00);
        repeat (4) @(negedge clk);
        chk({wcr[7], 6'h00, rn}, 8'h01);
        wr_reg(8'hC0);
        wait_cnt(7'h3F);
        chk({7'h00, rn}, 8'h00);
        wait_cnt(7'h3E);
        wait_cnt(7'h3D);
        chk({7'h00, n == 16384}, 8'h01);
        $display("done count");
    endtask
    task automatic t_resets;
        wr_reg(8'h7F);
        repeat (2) @(negedge clk);
        chk(wcr, 8'hFF);
        wr_reg(8'h80);
        pulse();
        halt = 1;
        @(negedge clk);
        halt = 0;
        pulse();
        rst = 1;
        hw = 1;
        @(negedge clk);
        rst = 0;
        @(negedge clk);
        wr_reg(8'h00);
        pulse();
        $display("done resets");
    endtask
    task automatic t_halt;
        opt = 0;
        wr_reg(8'hC1);
        wait_cnt(7'h40);
        halt = 1;
        @(negedge clk);
        halt = 0;
        chk({7'h00, rn}, 8'h01);
        repeat (1000) @(negedge clk);
        ew = 1;
        @(negedge clk);
        ew = 0;
        n = 0;
        while (rn !== 1'b0 && n < 20000) begin
            n++;
            @(negedge clk);
        end
        chk({7'h00, n == 16638}, 8'h01);
        $display("done halt");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (12) @(negedge clk);
        rst = 0;
        @(negedge clk);
        t_bounds();
        t_count();
        t_resets();
        t_halt();
        close_out();
    end
    // hang guard
    initial begin
        #9000000;
        fail_count++;
        close_out();
    end
endmodule
`default_nettype wire
